// ===== eewc_consts.svh
`ifndef EEWC_CONSTS_SVH
`define EEWC_CONSTS_SVH

// Line counts and source positions.
`define EEWC_NUM_LINES 21
`define EEWC_NUM_EXT 16
`define EEWC_NUM_GPIO 81
`define EEWC_SEL_W 7
`define EEWC_NUM_RTC 4
`define EEWC_LINE_SUPPLY 16
`define EEWC_LINE_RTC_LO 17
`define EEWC_LINE_RTC_HI 20

// Reset values.
`define EEWC_LINES_RST 21'h0
`define EEWC_SYNC_RST 3'h0

// Bounds used by checks, in core_clk cycles.
`define EEWC_EDGE_LAT_MAX 5

`endif

// ===== eewc_pkg.sv
`default_nettype none
`include "eewc_consts.svh"

package eewc_pkg;

	typedef logic [`EEWC_NUM_LINES-1:0] lineVec_t;

	typedef logic [`EEWC_NUM_EXT-1:0][`EEWC_SEL_W-1:0] extSel_t;

	typedef struct packed {
		logic alarm;
		logic wakeup;
		logic tamper;
		logic timestamp;
	} rtcEvt_t;

	typedef struct packed {
		logic standby;
		logic stop;
		logic sleep;
	} powerReq_t;

	typedef struct packed {
		logic poweredDown;
		logic clocksStopped;
		logic cpuHalted;
	} powerState_t;

	typedef enum logic [1:0] {
		LP_RUN,
		LP_SLEEP,
		LP_STOP,
		LP_STANDBY
	} lpState_t;

endpackage
`default_nettype wire

// ===== gpio_line_select.sv
`timescale 1ns/100ps
`default_nettype none
`include "eewc_consts.svh"

module gpio_line_select (
	// Pins and per-line selection
	input wire logic [`EEWC_NUM_GPIO-1:0] gpioIn,
	input wire eewc_pkg::extSel_t extSel,
	// Selected pin per external line
	output logic [`EEWC_NUM_EXT-1:0] extLine
);
	import eewc_pkg::*;

	// A select beyond the last pin gives a quiet low line.
	function automatic logic pickPin(input logic [`EEWC_NUM_GPIO-1:0] pins, input logic [`EEWC_SEL_W-1:0] sel);
		logic res;
		res = 1'b0;
		if (sel < `EEWC_SEL_W'(`EEWC_NUM_GPIO)) begin
			res = pins[sel];
		end
		return res;
	endfunction

	genvar g;
	generate
		for (g = 0; g < `EEWC_NUM_EXT; g++) begin : gSel
			assign extLine[g] = pickPin(gpioIn, extSel[g]);
		end
	endgenerate

endmodule
`default_nettype wire

// ===== edge_catch.sv
`timescale 1ns/100ps
`default_nettype none
`include "eewc_consts.svh"

module edge_catch (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Line watched without a clock
	input wire logic lineIn,
	// Edges seen, one core_clk pulse each
	output logic risePulse,
	output logic fallPulse
);
	import eewc_pkg::*;

	logic riseTgl_r;
	logic fallTgl_r;
	logic [2:0] riseSync_r;
	logic [2:0] fallSync_r;
	logic [2:0] riseSync_nxt;
	logic [2:0] fallSync_nxt;

	// The line itself clocks a toggle, so a pulse far shorter than a core_clk period is still kept.
	// Two edges of one direction between the same two core_clk edges cancel and give no pulse.
	always_ff @(posedge lineIn or posedge srst) begin
		if (srst) begin
			riseTgl_r <= 1'b0;
		end else begin
			riseTgl_r <= ~riseTgl_r;
		end
	end

	always_ff @(negedge lineIn or posedge srst) begin
		if (srst) begin
			fallTgl_r <= 1'b0;
		end else begin
			fallTgl_r <= ~fallTgl_r;
		end
	end

	always_comb begin
		riseSync_nxt = {riseSync_r[1:0], riseTgl_r};
		fallSync_nxt = {fallSync_r[1:0], fallTgl_r};
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			riseSync_r <= `EEWC_SYNC_RST;
			fallSync_r <= `EEWC_SYNC_RST;
		end else begin
			riseSync_r <= riseSync_nxt;
			fallSync_r <= fallSync_nxt;
		end
	end

	assign risePulse = riseSync_r[2] ^ riseSync_r[1];
	assign fallPulse = fallSync_r[2] ^ fallSync_r[1];

endmodule
`default_nettype wire

// ===== edge_event_wakeup_controller.sv
`timescale 1ns/100ps
`default_nettype none
`include "eewc_consts.svh"
// Operation
// - Twenty-one edge lines, each able to raise an interrupt or event request.
// - Each line picks rising, falling or both edges as its trigger.
// - Each line has its own mask; masked lines raise no request.
// - A per-line pending flag records a trigger until it is cleared.
// - Edges are caught without the clock, so very short pulses count.
// - Any of 81 pins can be chosen to feed each of 16 external lines.
// - Any enabled line wakes the device from stop mode.
// - The supply detector feeds a line, triggering on falling, rising or both.
// - In sleep mode any interrupt or event request wakes the processor.
// - Standby exits on reset pin, watchdog reset, wake pin rise or clock-calendar event.
// - On backup battery only, line and clock-calendar triggers cause no exit from stop or standby.

module edge_event_wakeup_controller (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Trigger sources
	input wire logic [`EEWC_NUM_GPIO-1:0] gpioIn,
	input wire eewc_pkg::extSel_t extSel,
	input wire logic supplyDetOut,
	input wire logic supplyDetEn,
	input wire eewc_pkg::rtcEvt_t rtcEvt,
	// Per-line configuration, bit n for line n
	input wire eewc_pkg::lineVec_t riseEn,
	input wire eewc_pkg::lineVec_t fallEn,
	input wire eewc_pkg::lineVec_t intUnmask,
	input wire eewc_pkg::lineVec_t evtUnmask,
	input wire eewc_pkg::lineVec_t pendClr,
	// Power control
	input wire eewc_pkg::powerReq_t powerReq,
	input wire logic vbatOnly,
	input wire logic wakePin,
	input wire logic extResetPin_n,
	input wire logic watchdogReset,
	// Status and requests
	output eewc_pkg::lineVec_t pending,
	output eewc_pkg::lineVec_t intReq,
	output eewc_pkg::lineVec_t evtReq,
	output eewc_pkg::powerState_t powerState,
	output logic wakeUp
);
	import eewc_pkg::*;

	lineVec_t srcLine;
	lineVec_t riseP;
	lineVec_t fallP;
	lineVec_t trig;
	logic [`EEWC_NUM_EXT-1:0] extLine;
	logic wakeRise;

	lineVec_t pending_r;
	lineVec_t pending_nxt;
	lineVec_t intReq_r;
	lineVec_t intReq_nxt;
	lineVec_t evtReq_r;
	lineVec_t evtReq_nxt;

	lpState_t state_r;
	lpState_t state_nxt;
	powerState_t powerState_r;
	powerState_t powerState_nxt;
	logic wakeUp_r;
	logic wakeUp_nxt;

	logic rtcTrig;
	logic stopCause;
	logic standbyCause;
	localparam int edgeLatMax = `EEWC_EDGE_LAT_MAX;

	function automatic logic anySet(input lineVec_t v);
		return |v;
	endfunction

	function automatic powerState_t decodeState(input lpState_t s);
		powerState_t p;
		p = '0;
		case (s)
			LP_SLEEP: begin
				p.cpuHalted = 1'b1;
			end
			LP_STOP: begin
				p.cpuHalted = 1'b1;
				p.clocksStopped = 1'b1;
			end
			LP_STANDBY: begin
				p.cpuHalted = 1'b1;
				p.clocksStopped = 1'b1;
				p.poweredDown = 1'b1;
			end
			default: begin
				p = '0;
			end
		endcase
		return p;
	endfunction

	gpio_line_select uSelect (
		.gpioIn(gpioIn),
		.extSel(extSel),
		.extLine(extLine)
	);

	// The detector line stays quiet until software turns the detector on.
	assign srcLine[`EEWC_NUM_EXT-1:0] = extLine;
	assign srcLine[`EEWC_LINE_SUPPLY] = supplyDetOut & supplyDetEn;
	assign srcLine[`EEWC_LINE_RTC_HI:`EEWC_LINE_RTC_LO] = rtcEvt;

	genvar g;
	generate
		for (g = 0; g < `EEWC_NUM_LINES; g++) begin : gLine
			edge_catch uCatch (
				.core_clk(core_clk),
				.srst(srst),
				.lineIn(srcLine[g]),
				.risePulse(riseP[g]),
				.fallPulse(fallP[g])
			);
		end
	endgenerate

	edge_catch uWakePin (
		.core_clk(core_clk),
		.srst(srst),
		.lineIn(wakePin),
		.risePulse(wakeRise),
		.fallPulse()
	);

	always_comb begin
		trig = (riseP & riseEn) | (fallP & fallEn);
		pending_nxt = (pending_r & ~pendClr) | trig;
		intReq_nxt = pending_nxt & intUnmask;
		evtReq_nxt = trig & evtUnmask;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			pending_r <= `EEWC_LINES_RST;
			intReq_r <= `EEWC_LINES_RST;
			evtReq_r <= `EEWC_LINES_RST;
		end else begin
			pending_r <= pending_nxt;
			intReq_r <= intReq_nxt;
			evtReq_r <= evtReq_nxt;
		end
	end

	// Battery-only operation blocks line and clock-calendar exits from stop and standby; sleep still wakes on a request, and pins and watchdog still act.
	always_comb begin
		rtcTrig = |trig[`EEWC_LINE_RTC_HI:`EEWC_LINE_RTC_LO] & ~vbatOnly;
		stopCause = anySet(trig & (intUnmask | evtUnmask)) & ~vbatOnly;
		standbyCause = ~extResetPin_n | watchdogReset | wakeRise | rtcTrig;
		state_nxt = state_r;
		wakeUp_nxt = 1'b0;
		case (state_r)
			LP_RUN: begin
				if (powerReq.standby) begin
					state_nxt = LP_STANDBY;
				end else if (powerReq.stop) begin
					state_nxt = LP_STOP;
				end else if (powerReq.sleep) begin
					state_nxt = LP_SLEEP;
				end
			end
			LP_SLEEP: begin
				if (anySet(intReq_nxt) | anySet(evtReq_nxt)) begin
					state_nxt = LP_RUN;
					wakeUp_nxt = 1'b1;
				end
			end
			LP_STOP: begin
				if (stopCause) begin
					state_nxt = LP_RUN;
					wakeUp_nxt = 1'b1;
				end
			end
			LP_STANDBY: begin
				if (standbyCause) begin
					state_nxt = LP_RUN;
					wakeUp_nxt = 1'b1;
				end
			end
			default: begin
				state_nxt = LP_RUN;
			end
		endcase
		powerState_nxt = decodeState(state_nxt);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_r <= LP_RUN;
			powerState_r <= '0;
			wakeUp_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			powerState_r <= powerState_nxt;
			wakeUp_r <= wakeUp_nxt;
		end
	end

	assign pending = pending_r;
	assign intReq = intReq_r;
	assign evtReq = evtReq_r;
	assign powerState = powerState_r;
	assign wakeUp = wakeUp_r;

	a_pend_set_wins: assert property (@(posedge core_clk) disable iff (srst)
		anySet(trig) |=> ((pending_r & $past(trig)) == $past(trig)))
		else $error("Pending flag lost a trigger.");

	a_pend_clear: assert property (@(posedge core_clk) disable iff (srst)
		anySet(pendClr) |=> ((pending_r & $past(pendClr & ~trig)) == '0))
		else $error("Pending flag not cleared by a one.");

	a_pend_hold: assert property (@(posedge core_clk) disable iff (srst)
		##1 ((pending_r & $past(pending_r & ~pendClr)) == $past(pending_r & ~pendClr)))
		else $error("Pending flag dropped without a clear.");

	a_int_needs_pend: assert property (@(posedge core_clk) disable iff (srst)
		(intReq_r & ~pending_r) == '0)
		else $error("Interrupt request without pending flag.");

	a_int_masked: assert property (@(posedge core_clk) disable iff (srst)
		##1 ((intReq_r & ~$past(intUnmask)) == '0))
		else $error("Masked line raised an interrupt.");

	a_evt_masked: assert property (@(posedge core_clk) disable iff (srst)
		##1 ((evtReq_r & ~$past(evtUnmask)) == '0))
		else $error("Masked line raised an event.");

	a_supply_edge: assert property (@(posedge core_clk) disable iff (srst)
		($rose(supplyDetOut) && supplyDetEn && riseEn[`EEWC_LINE_SUPPLY] && !pendClr[`EEWC_LINE_SUPPLY])
		|-> ##[1:edgeLatMax] (pending_r[`EEWC_LINE_SUPPLY] || pendClr[`EEWC_LINE_SUPPLY]))
		else $error("Supply detector edge not recorded.");

	a_sleep_wake: assert property (@(posedge core_clk) disable iff (srst)
		(state_r == LP_SLEEP && anySet(intReq_nxt)) |=> (wakeUp_r && state_r == LP_RUN))
		else $error("Sleep not left on a request.");

	a_stop_wake: assert property (@(posedge core_clk) disable iff (srst)
		(state_r == LP_STOP && !vbatOnly && anySet(trig & intUnmask)) |=> (state_r == LP_RUN && !powerState_r.clocksStopped))
		else $error("Stop not left on an enabled line.");

	a_standby_exit: assert property (@(posedge core_clk) disable iff (srst)
		(state_r == LP_STANDBY && (!extResetPin_n || watchdogReset)) |=> (wakeUp_r && !powerState_r.poweredDown))
		else $error("Standby not left on reset.");

	a_vbat_hold: assert property (@(posedge core_clk) disable iff (srst)
		(state_r == LP_STOP && vbatOnly) |=> (state_r == LP_STOP))
		else $error("Line trigger left stop on battery.");

	a_wake_pulse: assert property (@(posedge core_clk) disable iff (srst)
		wakeUp_r |=> !wakeUp_r)
		else $error("Wake pulse longer than one cycle.");

	a_int_follows: assert property (@(posedge core_clk) disable iff (srst)
		##1 (intReq_r == (pending_r & $past(intUnmask))))
		else $error("Interrupt request does not follow pending and mask.");

	a_int_holds: assert property (@(posedge core_clk) disable iff (srst)
		##1 (($past(intReq_r) & $past(intUnmask) & ~$past(pendClr) & ~intReq_r) == '0))
		else $error("Interrupt request dropped while pending and unmasked.");

	a_evt_needs_trig: assert property (@(posedge core_clk) disable iff (srst)
		##1 ((evtReq_r & ~$past(trig)) == '0))
		else $error("Event request without a trigger.");

	a_dir_refused: assert property (@(posedge core_clk) disable iff (srst)
		##1 ((pending_r & ~$past(pending_r) & ~$past(riseEn) & ~$past(fallEn)) == '0))
		else $error("Line with no enabled edge became pending.");

	// Turning the detector off while its output is high is itself a falling edge, so the check waits it out.
	a_supply_off: assert property (@(posedge core_clk) disable iff (srst)
		(!supplyDetEn)[*4] |-> !trig[`EEWC_LINE_SUPPLY])
		else $error("Disabled supply detector produced a trigger.");

	a_enter_stop: assert property (@(posedge core_clk) disable iff (srst)
		(state_r == LP_RUN && powerReq.stop && !powerReq.standby) |=> (state_r == LP_STOP))
		else $error("Stop request not taken.");

	a_sleep_evt_wake: assert property (@(posedge core_clk) disable iff (srst)
		(state_r == LP_SLEEP && anySet(evtReq_nxt)) |=> (wakeUp_r && state_r == LP_RUN))
		else $error("Sleep not left on an event.");

	a_standby_vbat: assert property (@(posedge core_clk) disable iff (srst)
		(state_r == LP_STANDBY && vbatOnly && extResetPin_n && !watchdogReset && !wakeRise) |=> state_r == LP_STANDBY)
		else $error("Standby left on battery without a pin or watchdog cause.");

	a_wake_pin_exit: assert property (@(posedge core_clk) disable iff (srst)
		(state_r == LP_STANDBY && wakeRise) |=> (wakeUp_r && state_r == LP_RUN))
		else $error("Standby not left on a wake pin rise.");

endmodule
`default_nettype wire

// ===== src_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "eewc_consts.svh"
module src_model (
	// Source lines
	output var logic [`EEWC_NUM_GPIO-1:0] gpioIn,
	output var logic supplyDetOut,
	output var eewc_pkg::rtcEvt_t rtcEvt,
	output var logic wakePin
);
	import eewc_pkg::*;
	initial begin
		gpioIn = '0;
		supplyDetOut = 1'b1;
		rtcEvt = '0;
		wakePin = 1'b0;
	end
	// Levels change with no regard to the clock, as real pins do.
	task automatic setPin(input int idx, input logic v);
		gpioIn[idx] = v;
	endtask
	// The detector output may move while disabled; the block must ignore it.
	task automatic setSupply(input logic v);
		supplyDetOut = v;
	endtask
	task automatic rtcPulse(input int w);
		rtcEvt.alarm = 1'b1;
		#(w);
		rtcEvt.alarm = 1'b0;
	endtask
	task automatic wakePulse();
		wakePin = 1'b1;
		#80;
		wakePin = 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== tb_edge_event_wakeup_controller.sv
`timescale 1ns/100ps
`default_nettype none
`include "eewc_consts.svh"
module tb_edge_event_wakeup_controller;
	import eewc_pkg::*;
	logic core_clk = 1'b0;
	logic srst = 1'b0;
	wire logic [`EEWC_NUM_GPIO-1:0] gpioIn;
	wire logic supplyDetOut;
	wire rtcEvt_t rtcEvt;
	wire logic wakePin;
	extSel_t extSel = '0;
	logic supplyDetEn = 1'b0;
	lineVec_t riseEn = '0;
	lineVec_t fallEn = '0;
	lineVec_t intUnmask = '0;
	lineVec_t evtUnmask = '0;
	lineVec_t pendClr = '0;
	powerReq_t powerReq = '0;
	logic vbatOnly = 1'b0;
	logic watchdogReset = 1'b0;
	logic extResetPin_n = 1'b1;
	lineVec_t pending;
	lineVec_t intReq;
	lineVec_t evtReq;
	powerState_t powerState;
	logic wakeUp;
	int num_errors = 0;
	int n_checks = 0;
	int evtCnt = 0;
	int wakeCnt = 0;
	always #20 core_clk = ~core_clk;
	// Pulses are counted so a stretched event or wake pulse shows up.
	always @(posedge core_clk) begin
		evtCnt <= evtCnt + $countones(evtReq);
		wakeCnt <= wakeCnt + int'(wakeUp === 1'b1);
	end
	src_model src_u (.gpioIn(gpioIn), .supplyDetOut(supplyDetOut), .rtcEvt(rtcEvt), .wakePin(wakePin));
	edge_event_wakeup_controller dut_u (.core_clk(core_clk), .srst(srst), .gpioIn(gpioIn), .extSel(extSel),
		.supplyDetOut(supplyDetOut), .supplyDetEn(supplyDetEn), .rtcEvt(rtcEvt), .riseEn(riseEn),
		.fallEn(fallEn), .intUnmask(intUnmask), .evtUnmask(evtUnmask), .pendClr(pendClr),
		.powerReq(powerReq), .vbatOnly(vbatOnly), .wakePin(wakePin), .extResetPin_n(extResetPin_n),
		.watchdogReset(watchdogReset), .pending(pending), .intReq(intReq), .evtReq(evtReq),
		.powerState(powerState), .wakeUp(wakeUp));
	task automatic step(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic clr(input int n);
		pendClr[n] = 1'b1;
		step(1);
		pendClr[n] = 1'b0;
		step(1);
		chk(pending[n], 1'b0);
	endtask
	task automatic enter(input powerReq_t r, input logic [2:0] exp);
		powerReq = r;
		step(1);
		powerReq = '0;
		step(2);
		chk(powerState, exp);
	endtask
	task automatic t_edge();
		int e0;
		e0 = evtCnt;
		extSel[0] = 7'h50;
		riseEn[0] = 1'b1;
		intUnmask[0] = 1'b1;
		evtUnmask[0] = 1'b1;
		src_u.setPin(80, 1'b1);
		step(5);
		chk(pending, 21'h000001);
		chk(intReq, 21'h000001);
		chk(evtCnt - e0, 1);
		src_u.setPin(80, 1'b0);
		step(5);
		chk(evtCnt - e0, 1);
		chk(pending, 21'h000001);
		clr(0);
		chk(intReq, 0);
		extSel[1] = 7'h7f;
		riseEn[1] = 1'b1;
		src_u.setPin(0, 1'b1);
		step(5);
		chk(pending, 0);
		src_u.setPin(0, 1'b0);
		riseEn[1] = 1'b0;
		step(5);
	endtask
	task automatic t_narrow();
		int e0;
		e0 = evtCnt;
		riseEn[20] = 1'b1;
		src_u.rtcPulse(5);
		step(5);
		chk(pending, 21'h100000);
		chk(intReq, 0);
		chk(evtCnt - e0, 0);
		clr(20);
	endtask
	task automatic t_supply();
		fallEn[16] = 1'b1;
		intUnmask[16] = 1'b1;
		src_u.setSupply(1'b0);
		step(5);
		chk(pending, 0);
		src_u.setSupply(1'b1);
		supplyDetEn = 1'b1;
		step(5);
		chk(pending, 0);
		src_u.setSupply(1'b0);
		step(5);
		chk(intReq, 21'h010000);
		clr(16);
		riseEn[16] = 1'b1;
		src_u.setSupply(1'b1);
		step(5);
		chk(pending, 21'h010000);
		clr(16);
	endtask
	task automatic t_power();
		int w0;
		w0 = wakeCnt;
		enter(3'b010, 3'h3);
		src_u.setPin(80, 1'b1);
		step(6);
		chk(powerState, 0);
		clr(0);
		fallEn[0] = 1'b1;
		enter(3'b001, 3'h1);
		src_u.setPin(80, 1'b0);
		step(6);
		chk(powerState, 0);
		clr(0);
		vbatOnly = 1'b1;
		enter(3'b100, 3'h7);
		src_u.rtcPulse(5);
		step(6);
		chk(powerState, 3'h7);
		src_u.wakePulse();
		step(8);
		chk(powerState, 0);
		enter(3'b100, 3'h7);
		watchdogReset = 1'b1;
		step(1);
		watchdogReset = 1'b0;
		step(3);
		chk(powerState, 0);
		chk(wakeCnt - w0, 4);
		vbatOnly = 1'b0;
		clr(20);
	endtask
	task automatic t_battery();
		int w0;
		w0 = wakeCnt;
		vbatOnly = 1'b1;
		enter(3'b010, 3'h3);
		src_u.setPin(80, 1'b1);
		step(6);
		chk(powerState, 3'h3);
		vbatOnly = 1'b0;
		src_u.setPin(80, 1'b0);
		step(6);
		chk(powerState, 0);
		clr(0);
		enter(3'b100, 3'h7);
		src_u.rtcPulse(5);
		step(6);
		chk(powerState, 0);
		clr(20);
		vbatOnly = 1'b1;
		enter(3'b100, 3'h7);
		extResetPin_n = 1'b0;
		step(1);
		extResetPin_n = 1'b1;
		step(3);
		chk(powerState, 0);
		chk(wakeCnt - w0, 3);
		vbatOnly = 1'b0;
	endtask
	task automatic t_reset();
		src_u.setPin(80, 1'b1);
		step(5);
		chk(pending, 21'h000001);
		srst = 1'b1;
		step(3);
		chk(pending, 0);
		chk(intReq, 0);
		chk(powerState, 0);
		srst = 1'b0;
		step(1);
		src_u.setPin(80, 1'b0);
		step(5);
		chk(pending, 21'h000001);
		chk(intReq, 21'h000001);
		clr(0);
	endtask
	task automatic summarize();
		if (num_errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// The whole sequence needs about 160 cycles; the limit leaves ample margin.
	initial begin
		#100000;
		num_errors++;
		summarize();
	end
	// Reset rises just after time zero so the asynchronous edge toggles see a real reset edge.
	initial begin
		#1;
		srst = 1'b1;
		step(3);
		srst = 1'b0;
		step(2);
		t_edge();
		t_narrow();
		t_supply();
		t_power();
		t_battery();
		t_reset();
		summarize();
	end
endmodule
`default_nettype wire
